// ==== inc/act_defines.svh ====
// Register map, field positions, reset values and counts for the converter timing block
// Notes on behaviour
// - Source bit 15 set routes internal RC oscillator ticks as conversion clock.
// - Source bit clear divides the instruction cycle clock by the divider field plus one.
// - Auto-sample field bits 12:8 sets sampling length in conversion clock periods.
// - Auto-sample value zero gives zero sampling periods; software should avoid it.
// - Divider field bits 7:0 gives conversion period of field plus one cycles.
`ifndef ACT_DEFINES_SVH
`define ACT_DEFINES_SVH

`define ACT_ADDR_W 4
`define ACT_TIMING_OFS 4'h0
`define ACT_STATUS_OFS 4'h4
`define ACT_CONTROL_OFS 4'h8

`define ACT_SRC_BIT 15
`define ACT_AUTO_SAMPLE_DURATION_HI 12
`define ACT_AUTO_SAMPLE_DURATION_LO 8
`define ACT_DIV_HI 7
`define ACT_DIV_LO 0
`define ACT_START_BIT 0

`define ACT_TIMING_RST 16'h0000
`define ACT_TIMING_WMASK 16'h9FFF

`define ACT_INSTR_DIV 2

`endif

// ==== inc/act_pkg.sv ====
// Types shared by the converter timing block
package act_pkg;

    typedef enum logic [0:0] {
        ACT_IDLE = 1'b0,
        ACT_SAMPLE = 1'b1
    } act_samp_state_t;

    typedef struct packed {
        logic [15:0] timing;
        act_samp_state_t state;
        logic [4:0] sampLeft;
        logic convTick;
        logic sampling;
        logic sampleDone;
        logic waitReq;
        logic [31:0] rdata;
        logic swStart;
    } act_top_state_t;

endpackage : act_pkg

// ==== src/act_clk_div.sv ====
// Enable-pulse divider: one output pulse per limit+1 input pulses
`timescale 1ns/100ps
module act_clk_div #(
    parameter int WIDTH = 8
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic tickIn,
    input wire logic [WIDTH-1:0] limit,
    output logic tickOut
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } act_div_state_t;

    act_div_state_t s_q;
    act_div_state_t s_d;

    always_comb begin
        s_d = s_q;
        tickOut = 1'b0;
        if (tickIn) begin
            // Compare with >= so a shrunken limit wraps at once instead of running to overflow
            if (s_q.cnt >= limit) begin
                s_d.cnt = '0;
                tickOut = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    a_div_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (tickIn && s_q.cnt >= limit) |=> (s_q.cnt == '0))
        else $error("divider did not wrap at its limit");

    a_div_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !tickIn |-> !tickOut ##1 $stable(s_q.cnt))
        else $error("divider moved without an input pulse");

endmodule : act_clk_div

// ==== src/act_timing_top.sv ====
// Converter clock source, clock divider and auto-sample timer with Avalon-MM registers
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "act_defines.svh"
module act_timing_top #(
    parameter int INSTR_DIV = `ACT_INSTR_DIV
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [`ACT_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rcClkEn,
    input wire logic sampleStart,
    output logic convClkTick,
    output logic sampling,
    output logic sampleDone,
    output logic convSourceRc
);

    localparam logic [7:0] INSTR_LIMIT = 8'(INSTR_DIV - 1);
    localparam int ACK_MIN = 1;
    localparam int ACK_MAX = 1;

    act_pkg::act_top_state_t s_q;
    act_pkg::act_top_state_t s_d;

    logic instrEn;
    logic divTick;
    logic startReq;
    logic [4:0] sampDur;

    function automatic logic [31:0] readReg(
        input logic [`ACT_ADDR_W-1:0] addr,
        input act_pkg::act_top_state_t st
    );
        logic [31:0] val;
        val = 32'h0000_0000;
        unique case (addr)
            `ACT_TIMING_OFS: val[15:0] = st.timing;
            `ACT_STATUS_OFS: begin
                val[0] = st.sampling;
                val[1] = st.timing[`ACT_SRC_BIT];
                val[12:8] = st.sampLeft;
            end
            default: val = 32'h0000_0000;
        endcase
        return val;
    endfunction : readReg

    function automatic logic [15:0] mergeLanes(
        input logic [15:0] oldVal,
        input logic [15:0] newVal,
        input logic [1:0] be
    );
        logic [15:0] res;
        res = oldVal;
        if (be[0]) begin
            res[7:0] = newVal[7:0];
        end
        if (be[1]) begin
            res[15:8] = newVal[15:8];
        end
        return res;
    endfunction : mergeLanes

    // Instruction cycle enable from the system clock
    act_clk_div #(
        .WIDTH(8)
    ) u_instr_div (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tickIn(1'b1),
        .limit(INSTR_LIMIT),
        .tickOut(instrEn)
    );

    // Conversion clock from instruction cycles
    act_clk_div #(
        .WIDTH(8)
    ) u_conv_div (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .tickIn(instrEn),
        .limit(s_q.timing[`ACT_DIV_HI:`ACT_DIV_LO]),
        .tickOut(divTick)
    );

    assign sampDur = s_q.timing[`ACT_AUTO_SAMPLE_DURATION_HI:`ACT_AUTO_SAMPLE_DURATION_LO];
    assign startReq = sampleStart || s_q.swStart;

    always_comb begin
        s_d = s_q;
        s_d.sampleDone = 1'b0;
        s_d.swStart = 1'b0;

        // Conversion clock source
        s_d.convTick = s_q.timing[`ACT_SRC_BIT] ? rcClkEn : divTick;

        // Auto-sample timer counts conversion clock periods
        unique case (s_q.state)
            act_pkg::ACT_IDLE: begin
                if (startReq) begin
                    if (sampDur == 5'h00) begin
                        s_d.sampleDone = 1'b1;
                    end else begin
                        s_d.state = act_pkg::ACT_SAMPLE;
                        s_d.sampLeft = sampDur;
                        s_d.sampling = 1'b1;
                    end
                end
            end
            act_pkg::ACT_SAMPLE: begin
                if (s_q.convTick) begin
                    s_d.sampLeft = s_q.sampLeft - 5'h01;
                    if (s_q.sampLeft == 5'h01) begin
                        s_d.state = act_pkg::ACT_IDLE;
                        s_d.sampling = 1'b0;
                        s_d.sampleDone = 1'b1;
                    end
                end
            end
        endcase

        // Avalon slave: acknowledge one cycle after the request, act at the acknowledge edge
        if (s_q.waitReq) begin
            if (avs_read || avs_write) begin
                s_d.waitReq = 1'b0;
                if (avs_read) begin
                    s_d.rdata = readReg(avs_address, s_q);
                end
            end
        end else begin
            s_d.waitReq = 1'b1;
            if (avs_write) begin
                unique case (avs_address)
                    `ACT_TIMING_OFS: begin
                        // Reserved bits are dropped and read back as zero
                        s_d.timing = mergeLanes(s_q.timing, avs_writedata[15:0], avs_byteenable[1:0])
                            & `ACT_TIMING_WMASK;
                    end
                    `ACT_CONTROL_OFS: begin
                        s_d.swStart = avs_byteenable[0] && avs_writedata[`ACT_START_BIT];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.timing <= `ACT_TIMING_RST;
            s_q.state <= act_pkg::ACT_IDLE;
            s_q.waitReq <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign avs_readdata = s_q.rdata;
    assign avs_waitrequest = s_q.waitReq;
    assign convClkTick = s_q.convTick;
    assign sampling = s_q.sampling;
    assign sampleDone = s_q.sampleDone;
    assign convSourceRc = s_q.timing[`ACT_SRC_BIT];

    // Helper logic read only by the checks below
    logic seenCycle_q;
    logic [4:0] durLatched_q;
    logic [5:0] tickCount_q;
    logic [8:0] instrCount_q;
    logic [7:0] prevDiv_q;
    logic divDirty_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            seenCycle_q <= 1'b0;
            durLatched_q <= 5'h00;
            tickCount_q <= 6'h00;
            instrCount_q <= 9'h000;
            prevDiv_q <= 8'h00;
            divDirty_q <= 1'b0;
        end else begin
            seenCycle_q <= 1'b1;
            prevDiv_q <= s_q.timing[7:0];
            if (s_q.state == act_pkg::ACT_IDLE && startReq) begin
                durLatched_q <= sampDur;
                tickCount_q <= 6'h00;
            end else if (s_q.state == act_pkg::ACT_SAMPLE && s_q.convTick) begin
                tickCount_q <= tickCount_q + 6'h01;
            end
            if (divTick) begin
                instrCount_q <= 9'h000;
                divDirty_q <= 1'b0;
            end else begin
                if (instrEn) begin
                    instrCount_q <= instrCount_q + 9'h001;
                end
                if (prevDiv_q != s_q.timing[7:0]) begin
                    divDirty_q <= 1'b1;
                end
            end
        end
    end

    a_rc_source_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        s_q.timing[`ACT_SRC_BIT] |-> ##1 (convClkTick == $past(rcClkEn)))
        else $error("conversion tick does not follow RC oscillator");

    a_sys_source_tick: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !s_q.timing[`ACT_SRC_BIT] |-> ##1 (convClkTick == $past(divTick)))
        else $error("conversion tick does not follow divided clock");

    a_div_period: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (divTick && !divDirty_q && prevDiv_q == s_q.timing[7:0])
        |-> (instrCount_q + 9'h001) == ({1'b0, s_q.timing[7:0]} + 9'h001))
        else $error("conversion period is not divider plus one cycles");

    a_sample_len: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (sampleDone && durLatched_q != 5'h00) |-> tickCount_q == {1'b0, durLatched_q})
        else $error("sampling length differs from auto-sample field");

    a_zero_sample: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (s_q.state == act_pkg::ACT_IDLE && startReq && sampDur == 5'h00) |=> (sampleDone && !sampling))
        else $error("zero auto-sample did not finish at once");

    a_reset_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !seenCycle_q |-> (s_q.timing == `ACT_TIMING_RST && !convSourceRc))
        else $error("timing register not cleared by reset");

    a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (!avs_waitrequest && avs_read && avs_address == `ACT_TIMING_OFS) |-> avs_readdata[14:13] == 2'b00)
        else $error("reserved timing bits read as non-zero");

    a_bus_ack: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ((avs_read || avs_write) && avs_waitrequest) |-> ##[ACK_MIN:ACK_MAX] !avs_waitrequest)
        else $error("bus request not acknowledged in time");

    a_ack_single: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !avs_waitrequest |=> avs_waitrequest)
        else $error("acknowledge lasted more than one cycle");

endmodule : act_timing_top

// ==== sim/test_act_timing_top.sv ====
// Self-checking bench for the converter timing block
`timescale 1ns/100ps
`include "act_defines.svh"
module test_act_timing_top;
    localparam int INSTR_DIV = 2;
    logic clk = 1'b0;
    logic rstN = 1'b0;
    logic [3:0] addr = 4'h0;
    logic rdS = 1'b0;
    logic wrS = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [31:0] rdata;
    logic waitReq;
    logic rcClkEn = 1'b0;
    logic sampleStart = 1'b0;
    logic convClkTick;
    logic sampling;
    logic sampleDone;
    logic convSourceRc;
    logic [31:0] rd;
    int nErrors = 0;
    int testsRun = 0;
    int c;

    act_timing_top #(.INSTR_DIV(INSTR_DIV)) dut (
        .ref_clk(clk), .arst_n(rstN), .avs_address(addr), .avs_read(rdS), .avs_write(wrS),
        .avs_writedata(wdata), .avs_byteenable(4'hF), .avs_readdata(rdata), .avs_waitrequest(waitReq),
        .rcClkEn(rcClkEn), .sampleStart(sampleStart), .convClkTick(convClkTick), .sampling(sampling),
        .sampleDone(sampleDone), .convSourceRc(convSourceRc)
    );

    always #10 clk = ~clk;

    task automatic stop_test();
        $display("Checks %0d errors %0d", testsRun, nErrors);
        if (nErrors == 0 && testsRun > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            nErrors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic check_cnt(input string name, input int exp, input int got);
        testsRun++;
        if (got != exp) begin
            nErrors++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_cnt

    // Holds the request until waitrequest is sampled low, then takes read data
    task automatic bus(input logic wr, input logic [3:0] a, input logic [15:0] wd, output logic [31:0] r);
        int n;
        logic ack;
        n = 0;
        ack = 1'b0;
        r = 32'h00000000;
        @(posedge clk);
        addr <= a;
        wdata <= {16'h0000, wd};
        wrS <= wr;
        rdS <= ~wr;
        // Settled values at the falling edge are what the next rising edge samples
        do begin
            @(negedge clk);
            n++;
            ack = (waitReq === 1'b0);
            r = rdata;
            @(posedge clk);
        end while (!ack && n < 50);
        wrS <= 1'b0;
        rdS <= 1'b0;
        if (!ack) begin
            check_cnt("bus answer", 1, 0);
            stop_test();
        end
    endtask : bus

    task automatic wait_tick(output int cyc);
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
        end while (convClkTick !== 1'b1 && cyc < 1000);
        if (cyc >= 1000) begin
            check_cnt("tick wait", 1, 0);
            stop_test();
        end
    endtask : wait_tick

    // Runs one auto-sample and counts conversion ticks seen while sampling
    task automatic run_sample(input logic [4:0] n, input logic viaReg);
        int k;
        int ticks;
        int saw;
        logic [31:0] r;
        k = 0;
        ticks = 0;
        saw = 0;
        bus(1'b1, `ACT_TIMING_OFS, {3'b000, n, 8'h01}, r);
        if (viaReg) begin
            bus(1'b1, `ACT_CONTROL_OFS, 16'h0001, r);
        end else begin
            @(posedge clk);
            sampleStart <= 1'b1;
        end
        do begin
            @(posedge clk);
            sampleStart <= 1'b0;
            k++;
            @(negedge clk);
            if (sampling === 1'b1 && convClkTick === 1'b1) ticks++;
            if (sampling === 1'b1) saw = 1;
        end while (sampleDone !== 1'b1 && k < 2000);
        if (k >= 2000) begin
            check_cnt("sample wait", 1, 0);
            stop_test();
        end
        check_cnt("sample periods", n, ticks);
        if (n == 5'h00) begin
            check_cnt("zero sample seen", 0, saw);
            if (!viaReg) check_cnt("zero sample latency", 1, k);
        end
        @(negedge clk);
        check("done pulse", 32'h0, {30'h0, sampling, sampleDone});
    endtask : run_sample

    initial begin
        int hits;
        int first;
        logic [7:0] divs [4];
        divs = '{8'h00, 8'h01, 8'h05, 8'h3F};
        repeat (20) @(posedge clk);
        rstN <= 1'b1;
        @(negedge clk);
        check("reset outputs", 32'h0, {28'h0, convClkTick, sampling, sampleDone, convSourceRc});
        bus(1'b0, `ACT_TIMING_OFS, 16'h0000, rd);
        check("timing reset", 32'h00000000, rd);
        bus(1'b1, `ACT_TIMING_OFS, 16'h9F3F, rd);
        bus(1'b0, `ACT_TIMING_OFS, 16'h0000, rd);
        check("timing readback", 32'h00009F3F, rd);
        check("source flag", 32'h1, {31'h0, convSourceRc});
        // Only the oscillator tick may produce a conversion tick now, one cycle after it
        hits = 0;
        first = -99;
        for (int k = -20; k < 6; k++) begin
            @(posedge clk);
            rcClkEn <= (k == -1);
            @(negedge clk);
            if (convClkTick === 1'b1) begin
                hits++;
                first = k;
            end
        end
        check_cnt("rc tick count", 1, hits);
        check_cnt("rc tick cycle", 0, first);
        bus(1'b0, `ACT_STATUS_OFS, 16'h0000, rd);
        check("status idle rc", 32'h00000002, rd);
        bus(1'b1, 4'hC, 16'h1234, rd);
        bus(1'b0, 4'hC, 16'h0000, rd);
        check("unmapped read", 32'h00000000, rd);
        bus(1'b0, `ACT_TIMING_OFS, 16'h0000, rd);
        check("timing kept", 32'h00009F3F, rd);
        foreach (divs[i]) begin
            bus(1'b1, `ACT_TIMING_OFS, {8'h00, divs[i]}, rd);
            wait_tick(c);
            wait_tick(c);
            check_cnt("divider period", (int'(divs[i]) + 1) * INSTR_DIV, c);
        end
        run_sample(5'h00, 1'b0);
        run_sample(5'h01, 1'b0);
        run_sample(5'h02, 1'b0);
        run_sample(5'h1F, 1'b0);
        run_sample(5'h03, 1'b1);
        stop_test();
    end
endmodule : test_act_timing_top
